// [inc/smb_ee_defs.svh]
`ifndef SMB_EE_DEFS_SVH
`define SMB_EE_DEFS_SVH

// control byte fields
`define SMB_CTL_DIR_BIT   0
`define SMB_CTL_OVR_BIT   1
`define SMB_CTL_NACK_BIT  3
`define SMB_CTL_FRM_BIT   5

// command code fields
`define SMB_CC_BLOCK_BIT  0
`define SMB_CC_FUNC_HI    3
`define SMB_CC_FUNC_LO    1
`define SMB_CC_FUNC_MEM   3'h2

// byte positions after the slave address
`define SMB_POS_CODE      4'h0
`define SMB_POS_LEN       4'h1
`define SMB_POS_CTL       4'h2
`define SMB_POS_TGT       4'h3
`define SMB_POS_LO        4'h4
`define SMB_POS_HI        4'h5
`define SMB_POS_DATA      4'h6
`define SMB_POS_PEC       4'h7
`define SMB_POS_MAX       4'hF

// length byte values
`define SMB_LEN_WR        8'h05
`define SMB_LEN_RD        8'h04
`define SMB_LEN_RET       8'h05

// packet error code and fill values
`define SMB_PEC_POLY      8'h07
`define SMB_PEC_INIT      8'h00
`define SMB_FILL_BYTE     8'hFF

`endif

// [inc/smb_ee_pkg.sv]
package smb_ee_pkg;

  // bit level engine states
  typedef enum logic [2:0] {
    E_IDLE = 3'b000,
    E_RX   = 3'b001,
    E_ACK  = 3'b010,
    E_LOAD = 3'b011,
    E_TX   = 3'b100,
    E_RACK = 3'b101
  } eng_st_t;

  // command parser states
  typedef enum logic [2:0] {
    C_IDLE = 3'b000,
    C_CODE = 3'b001,
    C_LEN  = 3'b010,
    C_BODY = 3'b011,
    C_TX   = 3'b100
  } cmd_st_t;

  // events from the bit engine, one cycle each
  typedef struct packed {
    logic       start;
    logic       stop;
    logic       byte_v;
    logic       is_addr;
    logic       rnw;
    logic [7:0] data;
  } link_ev_t;

  // request to the master bus memory engine
  typedef struct packed {
    logic        rd;
    logic [6:0]  target;
    logic [15:0] loc;
    logic [7:0]  wdata;
  } mem_req_t;

  // outcome from the master bus memory engine
  typedef struct packed {
    logic [7:0] rdata;
    logic       nack;
    logic       framing;
  } mem_rsp_t;

endpackage : smb_ee_pkg

// [hw/smb_link_engine.sv]
`include "smb_ee_defs.svh"

module smb_link_engine (
  // clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_arst_n,
  // bus pins, open drain
  input  wire logic                  i_scl,
  output logic                       o_scl_oe,
  input  wire logic                  i_sda,
  output logic                       o_sda_oe,
  // own address and transmit byte
  input  wire logic [6:0]            i_slave_addr,
  input  wire logic                  i_tx_valid,
  input  wire logic [7:0]            i_tx_byte,
  // receive events and transmit take
  output smb_ee_pkg::link_ev_t       o_ev,
  output logic                       o_tx_take
);
  import smb_ee_pkg::*;

  typedef struct packed {
    logic [1:0] scl_sy;
    logic [1:0] sda_sy;
    logic       scl_q;
    logic       sda_q;
    eng_st_t    st;
    logic [3:0] cnt;
    logic [7:0] sr;
    logic       addr_ph;
    logic       rnw;
    logic       mack;
    logic       sda_oe;
    link_ev_t   ev;
    logic       take;
  } eng_t;

  eng_t r, n;
  logic scl_s, sda_s, scl_rise, scl_fall, start_c, stop_c;

  // synchronised levels and bus conditions
  assign scl_s    = r.scl_sy[1];
  assign sda_s    = r.sda_sy[1];
  assign scl_rise = scl_s & ~r.scl_q;
  assign scl_fall = ~scl_s & r.scl_q;
  assign start_c  = scl_s & r.scl_q & r.sda_q & ~sda_s;
  assign stop_c   = scl_s & r.scl_q & ~r.sda_q & sda_s;

  // next state of the bit engine
  always_comb begin
    n        = r;
    n.scl_sy = {r.scl_sy[0], i_scl};
    n.sda_sy = {r.sda_sy[0], i_sda};
    n.scl_q  = scl_s;
    n.sda_q  = sda_s;
    n.ev     = '0;
    n.take   = 1'b0;
    case (r.st)
      E_RX: begin
        if (scl_rise) begin
          n.sr  = {r.sr[6:0], sda_s};
          n.cnt = r.cnt + 4'h1;
        end else if (scl_fall && r.cnt == 4'h8) begin
          n.addr_ph = 1'b0;
          if (!r.addr_ph || r.sr[7:1] == i_slave_addr) begin
            n.sda_oe     = 1'b1;
            n.st         = E_ACK;
            n.ev.byte_v  = 1'b1;
            n.ev.is_addr = r.addr_ph;
            n.ev.rnw     = r.sr[0];
            n.ev.data    = r.sr;
            if (r.addr_ph) begin
              n.rnw = r.sr[0];
            end
          end else begin
            n.st = E_IDLE;
          end
        end
      end
      E_ACK: begin
        if (scl_fall) begin
          n.sda_oe = 1'b0;
          n.cnt    = 4'h0;
          n.st     = r.rnw ? E_LOAD : E_RX;
        end
      end
      E_LOAD: begin
        if (i_tx_valid) begin
          n.sr     = i_tx_byte;
          n.sda_oe = ~i_tx_byte[7];
          n.cnt    = 4'h0;
          n.take   = 1'b1;
          n.st     = E_TX;
        end
      end
      E_TX: begin
        if (scl_fall) begin
          n.cnt = r.cnt + 4'h1;
          if (r.cnt == 4'h7) begin
            n.sda_oe = 1'b0;
            n.st     = E_RACK;
          end else begin
            n.sr     = {r.sr[6:0], 1'b0};
            n.sda_oe = ~r.sr[6];
          end
        end
      end
      E_RACK: begin
        if (scl_rise) begin
          n.mack = ~sda_s;
        end else if (scl_fall) begin
          n.st = r.mack ? E_LOAD : E_IDLE;
        end
      end
      E_IDLE: begin
        n.sda_oe = 1'b0;
      end
      default: begin
        n.st = E_IDLE;
      end
    endcase
    // start and stop override any bit position
    if (start_c) begin
      n.st       = E_RX;
      n.cnt      = 4'h0;
      n.addr_ph  = 1'b1;
      n.sda_oe   = 1'b0;
      n.ev.start = 1'b1;
    end else if (stop_c) begin
      n.st      = E_IDLE;
      n.sda_oe  = 1'b0;
      n.ev.stop = 1'b1;
    end
  end

  // state register
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // clock is stretched while no byte is ready to send
  assign o_scl_oe  = (r.st == E_LOAD);
  assign o_sda_oe  = r.sda_oe;
  assign o_ev      = r.ev;
  assign o_tx_take = r.take;

endmodule : smb_link_engine

// [hw/smb_ee_cmd.sv]
// Functional notes
// - bytes: code, length, control, target, location, data
// - length byte only in block transactions
// - length counts following bytes, status included
// - control bit 0 selects write or read
// - control bit 1 picks given or default target
// - location is low byte then high byte
// - data byte carries written or fetched value
// - nack fault flag on bit 3, one clears
// - nack flag shared with bus status register
// - framing fault flag on bit 5, one clears
// - unclaimed flags show whether command accepted
// - unknown function sets unclaimed flag after end
// - memory read is block write then read
// - memory write is one block write, PEC optional
// - plain non-block transactions also parsed
// - length byte never counts the PEC byte
`include "smb_ee_defs.svh"

module smb_ee_cmd (
  // clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_arst_n,
  // slave bus pins, open drain
  input  wire logic                  i_scl,
  output logic                       o_scl_o,
  output logic                       o_scl_oe,
  input  wire logic                  i_sda,
  output logic                       o_sda_o,
  output logic                       o_sda_oe,
  // configuration
  input  wire logic [6:0]            i_slave_addr,
  input  wire logic                  i_pec_en,
  input  wire logic [6:0]            i_default_target,
  // clears from the bus status register
  input  wire logic                  i_sts_nack_clr,
  input  wire logic                  i_sts_frm_clr,
  // master bus memory access
  output logic                       o_mem_start,
  output smb_ee_pkg::mem_req_t       o_mem_req,
  input  wire logic                  i_mem_done,
  input  wire smb_ee_pkg::mem_rsp_t  i_mem_rsp,
  // status
  output logic                       o_busy,
  output logic                       o_nack_fault,
  output logic                       o_framing_fault,
  output logic                       o_read_unclaimed,
  output logic                       o_write_unclaimed
);
  import smb_ee_pkg::*;

  typedef struct packed {
    cmd_st_t    st;
    logic [3:0] pos;
    logic       block;
    logic [7:0] cc;
    logic [7:0] len;
    logic [7:0] ctl;
    logic [7:0] tgt;
    logic [7:0] lo;
    logic [7:0] hi;
    logic [7:0] dat;
    logic [7:0] crc;
    logic       pec_ok;
    logic [3:0] tx_idx;
    logic       busy;
    logic       start;
    mem_req_t   req;
    logic       nack;
    logic       frm;
    logic       rd_unc;
    logic       wr_unc;
  } cmd_t;

  cmd_t       r, n;
  link_ev_t   ev;
  logic       tx_valid, tx_take;
  logic [7:0] tx_byte, ctl_ret;
  logic [3:0] tx_pos, body_cnt;
  logic [7:0] want;
  logic       op, accept;

  // one byte of the packet error code, polynomial x8+x2+x+1
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] x;
    x = c ^ d;
    for (int i = 0; i < 8; i++) begin
      x = x[7] ? ({x[6:0], 1'b0} ^ `SMB_PEC_POLY) : {x[6:0], 1'b0};
    end
    return x;
  endfunction : crc8

  // bit level slave engine
  smb_link_engine u_link (
    .i_clk        (i_clk),
    .i_arst_n     (i_arst_n),
    .i_scl        (i_scl),
    .o_scl_oe     (o_scl_oe),
    .i_sda        (i_sda),
    .o_sda_oe     (o_sda_oe),
    .i_slave_addr (i_slave_addr),
    .i_tx_valid   (tx_valid),
    .i_tx_byte    (tx_byte),
    .o_ev         (ev),
    .o_tx_take    (tx_take)
  );

  // returned control byte, reserved bits zero
  always_comb begin
    ctl_ret                    = 8'h00;
    ctl_ret[`SMB_CTL_DIR_BIT]  = r.ctl[`SMB_CTL_DIR_BIT];
    ctl_ret[`SMB_CTL_OVR_BIT]  = r.ctl[`SMB_CTL_OVR_BIT];
    ctl_ret[`SMB_CTL_NACK_BIT] = r.nack;
    ctl_ret[`SMB_CTL_FRM_BIT]  = r.frm;
  end

  // byte to return; no length byte outside block reads
  assign tx_pos   = r.block ? r.tx_idx + `SMB_POS_LEN : r.tx_idx + `SMB_POS_CTL;
  assign tx_valid = (r.st == C_TX) && !r.busy;
  always_comb begin
    case (tx_pos)
      `SMB_POS_LEN:  tx_byte = `SMB_LEN_RET;
      `SMB_POS_CTL:  tx_byte = ctl_ret;
      `SMB_POS_TGT:  tx_byte = r.tgt;
      `SMB_POS_LO:   tx_byte = r.lo;
      `SMB_POS_HI:   tx_byte = r.hi;
      `SMB_POS_DATA: tx_byte = r.dat;
      `SMB_POS_PEC:  tx_byte = i_pec_en ? r.crc : `SMB_FILL_BYTE;
      default:       tx_byte = `SMB_FILL_BYTE;
    endcase
  end

  // acceptance of a finished write sequence
  assign op       = (r.pos > `SMB_POS_CTL) && r.ctl[`SMB_CTL_DIR_BIT];
  assign want     = op ? `SMB_LEN_RD : `SMB_LEN_WR;
  assign body_cnt = (i_pec_en && r.pos > `SMB_POS_CTL) ? r.pos - `SMB_POS_TGT
                                                        : r.pos - `SMB_POS_CTL;
  assign accept   = (r.st == C_BODY) && !r.busy
                    && (r.cc[`SMB_CC_FUNC_HI:`SMB_CC_FUNC_LO] == `SMB_CC_FUNC_MEM)
                    && ({4'h0, body_cnt} == want)
                    && (!r.block || r.len == want)
                    && (!i_pec_en || r.pec_ok);

  // parser, request and flag logic
  always_comb begin
    n       = r;
    n.start = 1'b0;
    if (ev.start) begin
      n.st = C_IDLE;
    end else if (ev.byte_v && ev.is_addr) begin
      if (ev.rnw) begin
        n.st     = C_TX;
        n.tx_idx = 4'h0;
        n.crc    = crc8(r.crc, ev.data);
      end else begin
        n.st  = C_CODE;
        n.pos = `SMB_POS_CODE;
        n.crc = crc8(`SMB_PEC_INIT, ev.data);
      end
    end else if (ev.byte_v) begin
      n.crc = crc8(r.crc, ev.data);
      case (r.st)
        C_CODE: begin
          n.cc    = ev.data;
          n.block = ev.data[`SMB_CC_BLOCK_BIT];
          n.st    = ev.data[`SMB_CC_BLOCK_BIT] ? C_LEN : C_BODY;
          n.pos   = `SMB_POS_CTL;
        end
        C_LEN: begin
          n.len = ev.data;
          n.st  = C_BODY;
        end
        C_BODY: begin
          n.pec_ok = (r.crc == ev.data);
          if (r.pos != `SMB_POS_MAX) begin
            n.pos = r.pos + 4'h1;
          end
          case (r.pos)
            `SMB_POS_CTL:  n.ctl = ev.data;
            `SMB_POS_TGT:  n.tgt = ev.data;
            `SMB_POS_LO:   n.lo  = ev.data;
            `SMB_POS_HI:   n.hi  = ev.data;
            `SMB_POS_DATA: n.dat = ev.data;
            default:       n.pos = n.pos;
          endcase
        end
        default: begin
          n.st = r.st;
        end
      endcase
    end else if (ev.stop) begin
      if (r.st == C_LEN || r.st == C_BODY) begin
        if (accept) begin
          n.start      = 1'b1;
          n.busy       = 1'b1;
          n.req.rd     = op;
          n.req.target = r.ctl[`SMB_CTL_OVR_BIT] ? r.tgt[7:1] : i_default_target;
          n.req.loc    = {r.hi, r.lo};
          n.req.wdata  = r.dat;
        end
        if (op) begin
          n.rd_unc = !accept;
        end else begin
          n.wr_unc = !accept;
        end
      end
      n.st = C_IDLE;
    end
    // returned bytes extend the packet error code
    if (tx_take) begin
      n.tx_idx = r.tx_idx + 4'h1;
      n.crc    = crc8(r.crc, tx_byte);
    end
    // outcome of the master access; a set wins over any clear
    n.nack = r.nack & ~(i_sts_nack_clr | (n.start & r.ctl[`SMB_CTL_NACK_BIT]));
    n.frm  = r.frm & ~(i_sts_frm_clr | (n.start & r.ctl[`SMB_CTL_FRM_BIT]));
    if (i_mem_done && r.busy) begin
      n.busy = 1'b0;
      n.nack = n.nack | i_mem_rsp.nack;
      n.frm  = n.frm | i_mem_rsp.framing;
      if (r.req.rd) begin
        n.dat = i_mem_rsp.rdata;
      end
    end
  end

  // state register
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // outputs
  assign o_scl_o           = 1'b0;
  assign o_sda_o           = 1'b0;
  assign o_mem_start       = r.start;
  assign o_mem_req         = r.req;
  assign o_busy            = r.busy;
  assign o_nack_fault      = r.nack;
  assign o_framing_fault   = r.frm;
  assign o_read_unclaimed  = r.rd_unc;
  assign o_write_unclaimed = r.wr_unc;

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  a_dir_select: assert property (
    o_mem_start |-> o_mem_req.rd == r.ctl[`SMB_CTL_DIR_BIT])
    else $error("direction does not follow control bit 0");
  a_tgt_override: assert property (
    o_mem_start && r.ctl[`SMB_CTL_OVR_BIT] |-> o_mem_req.target == r.tgt[7:1])
    else $error("override target not taken from target byte");
  a_tgt_default: assert property (
    o_mem_start && !r.ctl[`SMB_CTL_OVR_BIT] |-> o_mem_req.target == $past(i_default_target))
    else $error("default target not used");
  a_loc_form: assert property (
    o_mem_start |-> o_mem_req.loc[15:8] == r.hi && o_mem_req.loc[7:0] == r.lo)
    else $error("location bytes misplaced");
  a_nack_set: assert property (
    i_mem_done && o_busy && i_mem_rsp.nack |=> o_nack_fault [*2])
    else $error("nack fault not set and held");
  a_frm_set: assert property (
    i_mem_done && o_busy && i_mem_rsp.framing |=> o_framing_fault)
    else $error("framing fault not set");
  a_nack_clr: assert property (
    i_sts_nack_clr && !(i_mem_done && o_busy) |=> !o_nack_fault)
    else $error("status clear did not clear nack fault");
  a_claim_flag: assert property (
    o_mem_start |-> (o_mem_req.rd ? !o_read_unclaimed : !o_write_unclaimed))
    else $error("accepted command marked unclaimed");
  a_stall_busy: assert property (
    o_busy |-> !tx_take)
    else $error("byte loaded during memory access");
  a_len_ret: assert property (
    tx_take && $past(tx_pos) == `SMB_POS_LEN |-> $past(tx_byte) == `SMB_LEN_RET)
    else $error("returned length byte wrong");

  // handshake, write data and flag clears around the master access
  a_busy_start: assert property (
    o_mem_start |-> o_busy)
    else $error("busy not raised with start");
  a_wdata_pass: assert property (
    o_mem_start |-> o_mem_req.wdata == r.dat)
    else $error("write data not passed to memory request");
  a_w1c_nack: assert property (
    o_mem_start && r.ctl[`SMB_CTL_NACK_BIT] |-> !o_nack_fault)
    else $error("control byte did not clear nack fault");
  a_frm_clr: assert property (
    i_sts_frm_clr && !(i_mem_done && o_busy) |=> !o_framing_fault)
    else $error("status clear did not clear framing fault");

  c_write_go: cover property (o_mem_start && !o_mem_req.rd);
  c_read_go:  cover property (o_mem_start && o_mem_req.rd);
  c_data_ret: cover property (tx_take && $past(tx_pos) == `SMB_POS_DATA);
  c_pec_ret:  cover property (tx_take && $past(tx_pos) == `SMB_POS_PEC);
  c_stretch:  cover property (o_scl_oe && o_busy);

endmodule : smb_ee_cmd

// [verif/smb_host_model.sv]
module smb_host_model (
  // wire levels
  input  wire logic i_scl,
  input  wire logic i_sda,
  // pulls, high drives the line low
  output logic      o_scl_oe,
  output logic      o_sda_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  int to_cnt = 0;

  // both lines released at power up
  initial begin
    o_scl_oe = 0;
    o_sda_oe = 0;
  end

  // release clock, bounded wait while the device stretches it
  task automatic scl_up;
    int n;
    o_scl_oe = 0;
    for (n = 0; n < 4000 && i_scl !== 1'b1; n++) #5;
    if (n == 4000) to_cnt++;
  endtask : scl_up

  // start, also a repeated start from a low clock
  task automatic start;
    #40 o_sda_oe = 0;
    #40;
    scl_up();
    #80 o_sda_oe = 1;
    #80 o_scl_oe = 1;
  endtask : start

  // stop, clock then stands high
  task automatic stop;
    #40 o_sda_oe = 1;
    #40;
    scl_up();
    #80 o_sda_oe = 0;
    #80;
  endtask : stop

  // one bit: data set in low phase, sampled mid high
  task automatic bit_io(input logic b, output logic s);
    #40 o_sda_oe = !b;
    #40;
    scl_up();
    #40 s = i_sda;
    #40 o_scl_oe = 1;
  endtask : bit_io

  // byte out, msb first, returns the ack
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask : wr_byte

  // byte in, nack after the last one
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, s);
  endtask : rd_byte
endmodule : smb_host_model

// [verif/smb_ee_cmd_tb_top.sv]
module smb_ee_cmd_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import smb_ee_pkg::*;
  localparam logic [6:0] SA = 7'h3A;
  localparam logic [6:0] DT = 7'h51;
  localparam logic [7:0] AW = {SA, 1'b0};
  logic     clk, arst_n, pec_en, nclr, fclr, done, scl_oe, sda_oe;
  logic     h_scl, h_sda, busy, nf, ff, ru, wu, mstart;
  mem_rsp_t rsp;
  mem_req_t req, req_seen;
  int       fail_count = 0;
  int       checks = 0;
  int       starts = 0;
  wire      scl = ~(scl_oe | h_scl);
  wire      sda = ~(sda_oe | h_sda);

  smb_ee_cmd dut_u (
    .i_clk(clk), .i_arst_n(arst_n), .i_scl(scl), .o_scl_o(), .o_scl_oe(scl_oe),
    .i_sda(sda), .o_sda_o(), .o_sda_oe(sda_oe), .i_slave_addr(SA), .i_pec_en(pec_en),
    .i_default_target(DT), .i_sts_nack_clr(nclr), .i_sts_frm_clr(fclr),
    .o_mem_start(mstart), .o_mem_req(req), .i_mem_done(done), .i_mem_rsp(rsp),
    .o_busy(busy), .o_nack_fault(nf), .o_framing_fault(ff), .o_read_unclaimed(ru),
    .o_write_unclaimed(wu)
  );
  smb_host_model host_u (.i_scl(scl), .i_sda(sda), .o_scl_oe(h_scl), .o_sda_oe(h_sda));

  // clock
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end

  // count and keep each memory request
  always @(posedge clk) begin
    if (mstart === 1'b1) begin
      starts++;
      req_seen = req;
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize

  function automatic logic [7:0] crc8(input logic [7:0] b[$]);
    logic [7:0] c;
    c = 8'h00;
    foreach (b[i]) begin
      c = c ^ b[i];
      repeat (8) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
    end
    return c;
  endfunction : crc8

  // one write transfer, every byte must be acked
  task automatic send(input logic [7:0] b[$], input bit stop);
    logic ack;
    host_u.start();
    foreach (b[i]) begin
      host_u.wr_byte(b[i], ack);
      chk("byte ack", 1, ack);
    end
    if (stop) begin
      host_u.stop();
      repeat (20) @(negedge clk);
    end
    if (host_u.to_cnt != 0) begin
      fail_count++;
      summarize();
    end
  endtask : send

  // memory engine answer after a delay
  task automatic finish_mem(input logic [7:0] rd, input logic nk, input logic fr, input int dly);
    int n;
    for (n = 0; n < 400 && busy !== 1'b1; n++) @(negedge clk);
    if (n == 400) begin
      fail_count++;
      summarize();
    end
    repeat (dly) @(negedge clk);
    rsp = '{rdata: rd, nack: nk, framing: fr};
    done = 1;
    @(negedge clk);
    done = 0;
    @(negedge clk);
    chk("busy drop", 0, busy);
  endtask : finish_mem

  // block write with given target, ends in a nack fault
  task automatic s_write;
    send('{AW, 8'h05, 8'h05, 8'h02, {7'h2C, 1'b0}, 8'h34, 8'h12, 8'hA5}, 1);
    chk("start count", 1, starts);
    chk("write req", {1'b0, 7'h2C, 16'h1234, 8'hA5}, req_seen);
    chk("write unclaimed", 0, wu);
    finish_mem(8'h00, 1, 0, 10);
    chk("nack fault", 1, nf);
  endtask : s_write

  // read setup then block read, clock stretched until the access ends
  task automatic s_read;
    logic [7:0] d[6];
    logic       ack;
    send('{AW, 8'h05, 8'h04, 8'h01, 8'h00, 8'h78, 8'h56}, 1);
    chk("read req", {1'b1, DT, 16'h5678}, req_seen[31:8]);
    chk("read unclaimed", 0, ru);
    fork
      begin
        send('{AW, 8'h05}, 0);
        host_u.start();
        host_u.wr_byte({SA, 1'b1}, ack);
        foreach (d[i]) host_u.rd_byte(i == 5, d[i]);
        host_u.stop();
      end
      finish_mem(8'hC3, 0, 1, 1400);
    join
    chk("read addr ack", 1, ack);
    chk("length", 5, d[0]);
    chk("ctl flags", 8'h29, d[1]);
    chk("target", 8'h00, d[2]);
    chk("location", 16'h5678, {d[4], d[3]});
    chk("data", 8'hC3, d[5]);
    chk("framing flag", 1, ff);
  endtask : s_read

  // plain write without length, one-to-clear, then status clears
  task automatic s_clear;
    send('{AW, 8'h04, 8'h28, 8'h00, 8'h10, 8'h00, 8'h5A}, 1);
    chk("start count", 3, starts);
    chk("w1c flags", 0, {nf, ff});
    chk("plain req", {1'b0, DT, 16'h0010, 8'h5A}, req_seen);
    finish_mem(8'h00, 1, 1, 10);
    chk("both flags", 3, {nf, ff});
    nclr = 1;
    fclr = 1;
    @(negedge clk);
    nclr = 0;
    fclr = 0;
    @(negedge clk);
    chk("status clears", 0, {nf, ff});
  endtask : s_clear

  // unknown function and wrong length are refused
  task automatic s_refuse;
    send('{AW, 8'h07, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h11}, 1);
    send('{AW, 8'h05, 8'h05, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00}, 1);
    chk("refused starts", 3, starts);
    chk("write unclaimed", 1, wu);
    chk("read unclaimed", 1, ru);
  endtask : s_refuse

  // block write with packet error code, top location
  task automatic s_pec;
    logic [7:0] q[$];
    q = '{AW, 8'h05, 8'h05, 8'h02, 8'hA0, 8'hFF, 8'hFF, 8'h3C};
    pec_en = 1;
    q.push_back(crc8(q));
    send(q, 1);
    chk("pec starts", 4, starts);
    chk("pec req", {1'b0, 7'h50, 16'hFFFF, 8'h3C}, req_seen);
    chk("write unclaimed", 0, wu);
    finish_mem(8'h00, 0, 0, 10);
    pec_en = 0;
  endtask : s_pec

  // main sequence
  initial begin
    {arst_n, pec_en, nclr, fclr, done} = '0;
    rsp = '0;
    repeat (6) @(negedge clk);
    arst_n = 1;
    repeat (10) @(negedge clk);
    s_write();
    s_read();
    s_clear();
    s_refuse();
    s_pec();
    summarize();
  end
endmodule : smb_ee_cmd_tb_top
